/* cpc_regs.vh */
// Register offsets, field positions, reset values and timing counts of the charge phase controller
`ifndef CPC_REGS_VH
`define CPC_REGS_VH

`define CPC_OFS_CTRL       8'h00
`define CPC_OFS_LIMIT      8'h04
`define CPC_OFS_FLOOR      8'h08
`define CPC_OFS_STATUS     8'h0c
`define CPC_OFS_IRQ_STAT   8'h10
`define CPC_OFS_IRQ_MASK   8'h14
`define CPC_OFS_TARGET     8'h18

// Control register fields
`define CPC_CTRL_DSEL      0
`define CPC_CTRL_TRK_LVL   1
`define CPC_CTRL_SENSE     2
`define CPC_CTRL_PRE_DIS   3
`define CPC_CTRL_TGT_SRC   4
`define CPC_CTRL_TERM_DIS  5
`define CPC_CTRL_TERM_SEL  6
`define CPC_CTRL_MASK      16'h737f
`define CPC_CTRL_RST       16'h1000
`define CPC_LIMIT_MASK     32'h0707ff7f
`define CPC_LIMIT_RST      32'h0000ff7f
`define CPC_FLOOR_RST      9'h02c

// Interrupt bits
`define CPC_IRQ_EOC        0
`define CPC_IRQ_RECH       1
`define CPC_IRQ_FLOOR      2

// Phases
`define CPC_PH_IDLE        3'h0
`define CPC_PH_TRICKLE     3'h1
`define CPC_PH_CC          3'h2
`define CPC_PH_CV          3'h3
`define CPC_PH_EOC         3'h4

// Cell reference, percentages, end of charge divisors, clamp and derating step
`define CPC_CELL_REF_MV    16'd4200
`define CPC_TRK_HI_PCT     24'd70
`define CPC_TRK_LO_PCT     24'd60
`define CPC_CV_PCT         24'd98
`define CPC_RECH_PCT       24'd95
`define CPC_TRK_BUS_PCT    24'd22
`define CPC_TRK_BAT_PCT    24'd10
`define CPC_EOC_DIV_HI     24'd10
`define CPC_EOC_DIV_LO     24'd25
`define CPC_CLAMP_MV       16'd125
`define CPC_DERATE_STEP_MA 16'd50

// Timing: one time unit of the alert pulse is one millisecond tick
`define CPC_CLK_HZ         20000000
`define CPC_TICK_US        1000
`define CPC_TICK_CYC       ((`CPC_CLK_HZ / 1000000) * `CPC_TICK_US)
`define CPC_DEGLITCH_MS    8'd220
`define CPC_ALERT_TICKS    2'd1

`endif

/* cpc_sync3.v */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module cpc_sync3 #(
    parameter RST_VAL = 1'b0
) (
    input  wire clk_sys,
    input  wire sys_rst,
    input  wire pin_in,
    output reg  level
);
    reg s1;
    reg s2;
    reg s3;

    // s1 feeds s2 only; a change counts once s2 and s3 agree
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            s1    <= RST_VAL;
            s2    <= RST_VAL;
            s3    <= RST_VAL;
            level <= RST_VAL;
        end else begin
            s1 <= pin_in;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                level <= s3;
            end
        end
    end
endmodule

/* cpc_tick.v */
// Divider producing a one-cycle enable every DIV cycles
`timescale 1ns/1ps
module cpc_tick #(
    parameter DIV = 20000
) (
    input  wire clk_sys,
    input  wire sys_rst,
    output reg  tick
);
    reg [23:0] cnt;

    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cnt  <= 24'h000000;
            tick <= 1'b0;
        end else if (cnt == DIV - 1) begin
            cnt  <= 24'h000000;
            tick <= 1'b1;
        end else begin
            cnt  <= cnt + 24'h000001;
            tick <= 1'b0;
        end
    end
endmodule

/* cpc_charge_phase.v */
// Charge phase sequencer with APB register file, input floor derating and alert pulse
//
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
`include "cpc_regs.vh"
////////////////////////////////////////////////////////////////////////////////
// What this block does
// - Select bit clear means charging mode, energy from bus to battery.
// - Trickle threshold is 70% or 60% of 4.2V per cell times cells, or of the external target when that source is selected.
// - Trickle limits input current to 22% or battery current to 10%.
// - Precharge disable skips trickle and goes straight to constant current.
// - Constant current regulates whichever current limit is reached first.
// - External target source ignores cell count and per-cell voltage fields.
// - Constant voltage starts at 98% of target and holds the target.
// - End of charge needs voltage above 98% and current below 1/10 or 1/25.
// - In end of charge, termination disable picks stop or keep regulating.
// - After termination, below 95% clears the flag and re-enters constant current.
// - Bus sag to the floor threshold reduces charging current automatically.
// - Floor code is scaled by the floor scale bit, 0x2C is 4.5V, 0x95 15V.
// - Constant voltage target rises by current times impedance, capped at 125mV.
// - Input current scale 01 means 6x, 10 means 3x.
// - Charging starts 220 ms after the power stop pin goes low.
// - Each alert is an active-low pulse of one time unit.
module cpc_charge_phase #(
    parameter TICK_CYC = `CPC_TICK_CYC
) (
    input  wire        clk_sys,
    input  wire        sys_rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        power_stop_pin,
    input  wire [15:0] bat_mv,
    input  wire [15:0] bus_mv,
    input  wire [15:0] bat_ma,
    input  wire [15:0] bus_ma,
    input  wire [15:0] ext_target_mv,
    output reg         charge_mode,
    output reg         charge_enable,
    output reg  [2:0]  phase_out,
    output reg  [15:0] bus_limit_ma,
    output reg  [15:0] bat_limit_ma,
    output reg  [15:0] vreg_mv,
    output reg         bus_loop,
    output reg         floor_active,
    output reg         eoc_flag,
    output reg         irq,
    output reg         alert_n
);
    ////////////////////////////////////////////////////////////////////////////
    // Registers and fields
    reg  [15:0] ctrl;
    reg  [31:0] limit;
    reg  [8:0]  floor_cfg;
    reg  [2:0]  irq_stat;
    reg  [2:0]  irq_mask;
    reg  [2:0]  phase;
    reg  [15:0] derate_ma;
    reg  [7:0]  dg_cnt;
    reg  [1:0]  alert_cnt;
    reg         alert_pend;
    reg         floor_prev;

    wire        charge_discharge_select       = ctrl[`CPC_CTRL_DSEL];
    wire        trickle_level_select          = ctrl[`CPC_CTRL_TRK_LVL];
    wire        charge_current_sense_select   = ctrl[`CPC_CTRL_SENSE];
    wire        precharge_disable             = ctrl[`CPC_CTRL_PRE_DIS];
    wire        target_source_select          = ctrl[`CPC_CTRL_TGT_SRC];
    wire        termination_disable           = ctrl[`CPC_CTRL_TERM_DIS];
    wire        termination_select            = ctrl[`CPC_CTRL_TERM_SEL];
    wire [1:0]  series_cell_count             = ctrl[9:8];
    wire [2:0]  per_cell_voltage_select       = ctrl[14:12];
    wire [6:0]  input_current_limit_code      = limit[6:0];
    wire [7:0]  battery_current_limit_code    = limit[15:8];
    wire [1:0]  input_current_scale           = limit[17:16];
    wire        battery_current_scale         = limit[18];
    wire [2:0]  impedance_comp_value          = limit[26:24];
    wire [7:0]  floor_code                    = floor_cfg[7:0];
    wire        floor_scale                   = floor_cfg[8];

    wire        tick;
    wire        stop_level;

    cpc_tick #(.DIV(TICK_CYC)) u_tick (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .tick    (tick)
    );

    cpc_sync3 #(.RST_VAL(1'b1)) u_stop_sync (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .pin_in  (power_stop_pin),
        .level   (stop_level)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Targets and thresholds
    reg  [15:0] cell_mv;
    always @* begin
        case (per_cell_voltage_select)
            3'h0:    cell_mv = 16'd4100;
            3'h1:    cell_mv = 16'd4200;
            3'h2:    cell_mv = 16'd4250;
            3'h3:    cell_mv = 16'd4300;
            3'h4:    cell_mv = 16'd4350;
            3'h5:    cell_mv = 16'd4400;
            3'h6:    cell_mv = 16'd4450;
            default: cell_mv = 16'd4500;
        endcase
    end

    wire [15:0] cells_n    = {13'h0000, {1'b0, series_cell_count} + 3'h1};
    wire [15:0] int_tgt    = cells_n * cell_mv;
    wire [15:0] target_mv  = target_source_select ? ext_target_mv : int_tgt;
    wire [15:0] trk_ref    = target_source_select ? ext_target_mv
                                                  : cells_n * `CPC_CELL_REF_MV;
    wire [23:0] trk_pct    = trickle_level_select ? `CPC_TRK_LO_PCT
                                                  : `CPC_TRK_HI_PCT;
    wire [23:0] v100       = bat_mv * 24'd100;
    wire [23:0] tgt98      = target_mv * `CPC_CV_PCT;
    wire        below_trk  = v100 < trk_ref * trk_pct;
    wire        at_cv      = v100 >= tgt98;
    wire        above_eoc  = v100 > tgt98;
    wire        below_rech = v100 < target_mv * `CPC_RECH_PCT;

    ////////////////////////////////////////////////////////////////////////////
    // Current limits in mA, full scale at the top code with a 10 mOhm sense
    wire [15:0] bus_full   = (input_current_scale == 2'b10) ? 16'd3000 : 16'd6000;
    wire [15:0] bat_full   = battery_current_scale ? 16'd12000 : 16'd6000;
    wire [23:0] bus_prod   = ({17'h00000, input_current_limit_code} + 24'd1) * bus_full;
    wire [23:0] bat_prod   = ({16'h0000, battery_current_limit_code} + 24'd1) * bat_full;
    wire [15:0] bus_lim    = bus_prod[22:7];
    wire [15:0] bat_lim    = bat_prod[23:8];
    wire [23:0] bus_trk    = (bus_lim * `CPC_TRK_BUS_PCT) / 24'd100;
    wire [23:0] bat_trk    = (bat_lim * `CPC_TRK_BAT_PCT) / 24'd100;
    wire        trickle    = (phase == `CPC_PH_TRICKLE);
    wire [15:0] bus_base   = (trickle & ~charge_current_sense_select) ? bus_trk[15:0]
                                                                      : bus_lim;
    wire [15:0] bat_base   = (trickle & charge_current_sense_select) ? bat_trk[15:0]
                                                                     : bat_lim;

    // End of charge current test on the selected side
    wire [15:0] i_sel      = charge_current_sense_select ? bat_ma : bus_ma;
    wire [15:0] lim_sel    = charge_current_sense_select ? bat_lim : bus_lim;
    wire [23:0] i_div      = i_sel * (termination_select ? `CPC_EOC_DIV_HI
                                                         : `CPC_EOC_DIV_LO);
    wire        i_low      = i_div < {8'h00, lim_sel};

    // The loop whose current sits closer to its own limit takes control
    wire [31:0] bus_frac   = bus_ma * bat_lim;
    wire [31:0] bat_frac   = bat_ma * bus_lim;

    ////////////////////////////////////////////////////////////////////////////
    // Input floor and impedance compensation
    wire [15:0] floor_mv   = floor_scale ? (floor_code * 16'd40 + 16'd40)
                                         : (floor_code * 16'd100 + 16'd100);
    wire [23:0] comp_raw   = (bat_ma * {21'h000000, impedance_comp_value}) / 24'd50;
    wire [15:0] comp_mv    = (comp_raw > {8'h00, `CPC_CLAMP_MV}) ? `CPC_CLAMP_MV
                                                               : comp_raw[15:0];

    ////////////////////////////////////////////////////////////////////////////
    // Session gating and phase sequencer
    wire        dg_done    = (dg_cnt == `CPC_DEGLITCH_MS);
    wire        run        = ~charge_discharge_select & dg_done;
    wire        floor_hit  = run & (phase != `CPC_PH_IDLE) & (bus_mv <= floor_mv);
    reg  [2:0]  next_phase;

    always @* begin
        next_phase = phase;
        case (phase)
            `CPC_PH_IDLE: begin
                if (run) begin
                    next_phase = (below_trk & ~precharge_disable) ? `CPC_PH_TRICKLE
                                                                  : `CPC_PH_CC;
                end
            end
            `CPC_PH_TRICKLE: begin
                if (precharge_disable | ~below_trk) begin
                    next_phase = `CPC_PH_CC;
                end
            end
            `CPC_PH_CC: begin
                if (at_cv) begin
                    next_phase = `CPC_PH_CV;
                end
            end
            `CPC_PH_CV: begin
                if (above_eoc & i_low) begin
                    next_phase = `CPC_PH_EOC;
                end
            end
            `CPC_PH_EOC: begin
                if (~termination_disable & below_rech) begin
                    next_phase = `CPC_PH_CC;
                end
            end
            default: next_phase = `CPC_PH_IDLE;
        endcase
        if (~run) begin
            next_phase = `CPC_PH_IDLE;
        end
    end

    wire ev_eoc   = (phase == `CPC_PH_CV) & (next_phase == `CPC_PH_EOC);
    wire ev_rech  = (phase == `CPC_PH_EOC) & (next_phase == `CPC_PH_CC);
    wire ev_floor = floor_hit & ~floor_prev;
    wire [2:0] events = {ev_floor, ev_rech, ev_eoc};

    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            phase      <= `CPC_PH_IDLE;
            eoc_flag   <= 1'b0;
            floor_prev <= 1'b0;
            dg_cnt     <= 8'h00;
            derate_ma  <= 16'h0000;
        end else begin
            phase      <= next_phase;
            floor_prev <= floor_hit;
            if (ev_eoc) begin
                eoc_flag <= 1'b1;
            end else if (ev_rech | ~run) begin
                eoc_flag <= 1'b0;
            end
            // Pin high restarts the wait; low must hold a full interval
            if (stop_level) begin
                dg_cnt <= 8'h00;
            end else if (tick & ~dg_done) begin
                dg_cnt <= dg_cnt + 8'h01;
            end
            // Step down while sagging, recover by the same step per tick once the bus lifts
            if (tick) begin
                if (floor_hit) begin
                    if (derate_ma < bus_base) begin
                        derate_ma <= derate_ma + `CPC_DERATE_STEP_MA;
                    end
                end else if (derate_ma >= `CPC_DERATE_STEP_MA) begin
                    derate_ma <= derate_ma - `CPC_DERATE_STEP_MA;
                end else begin
                    derate_ma <= 16'h0000;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registered outputs to the power stage
    wire stopped = (phase == `CPC_PH_EOC) & ~termination_disable;

    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            charge_mode   <= 1'b1;
            charge_enable <= 1'b0;
            phase_out     <= `CPC_PH_IDLE;
            bus_limit_ma  <= 16'h0000;
            bat_limit_ma  <= 16'h0000;
            vreg_mv       <= 16'h0000;
            bus_loop      <= 1'b0;
            floor_active  <= 1'b0;
        end else begin
            charge_mode   <= ~charge_discharge_select;
            charge_enable <= (phase != `CPC_PH_IDLE) & ~stopped;
            phase_out     <= phase;
            bus_limit_ma  <= (bus_base > derate_ma) ? bus_base - derate_ma
                                                    : 16'h0000;
            bat_limit_ma  <= bat_base;
            vreg_mv       <= (phase == `CPC_PH_CV) ? target_mv + comp_mv
                                                   : target_mv;
            bus_loop      <= (bus_frac >= bat_frac);
            floor_active  <= floor_hit;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Alert pulse, aligned to the tick so its width is one whole unit
    reg [1:0] next_alert_cnt;
    always @* begin
        next_alert_cnt = alert_cnt;
        if (tick) begin
            if (alert_cnt != 2'd0) begin
                next_alert_cnt = alert_cnt - 2'd1;
            end else if (alert_pend) begin
                next_alert_cnt = `CPC_ALERT_TICKS;
            end
        end
    end

    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            alert_cnt  <= 2'd0;
            alert_pend <= 1'b0;
            alert_n    <= 1'b1;
        end else begin
            alert_cnt <= next_alert_cnt;
            alert_n   <= (next_alert_cnt == 2'd0);
            if (|(events & irq_mask)) begin
                alert_pend <= 1'b1;
            end else if (tick & (alert_cnt == 2'd0)) begin
                alert_pend <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB slave, one wait state
    wire        access = psel & penable & ~pready;
    wire        wr     = access & pwrite;
    wire [2:0]  w1c    = (wr && paddr == `CPC_OFS_IRQ_STAT) ? pwdata[2:0] : 3'h0;
    reg  [31:0] rd_val;
    reg         rd_err;

    always @* begin
        rd_err = 1'b0;
        case (paddr)
            `CPC_OFS_CTRL:     rd_val = {16'h0000, ctrl};
            `CPC_OFS_LIMIT:    rd_val = limit;
            `CPC_OFS_FLOOR:    rd_val = {23'h000000, floor_cfg};
            `CPC_OFS_STATUS:   rd_val = {23'h000000, stop_level, bus_loop, run,
                                         floor_active, eoc_flag, 1'b0, phase};
            `CPC_OFS_IRQ_STAT: rd_val = {29'h00000000, irq_stat};
            `CPC_OFS_IRQ_MASK: rd_val = {29'h00000000, irq_mask};
            `CPC_OFS_TARGET:   rd_val = {floor_mv, vreg_mv};
            default: begin
                rd_val = 32'h00000000;
                rd_err = 1'b1;
            end
        endcase
    end

    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl      <= `CPC_CTRL_RST;
            limit     <= `CPC_LIMIT_RST;
            floor_cfg <= `CPC_FLOOR_RST;
            irq_mask  <= 3'h0;
            irq_stat  <= 3'h0;
            irq       <= 1'b0;
            pready    <= 1'b0;
            pslverr   <= 1'b0;
            prdata    <= 32'h00000000;
        end else begin
            pready  <= access;
            pslverr <= access & rd_err;
            prdata  <= (access & ~pwrite) ? rd_val : 32'h00000000;
            if (wr) begin
                case (paddr)
                    `CPC_OFS_CTRL:     ctrl      <= pwdata[15:0] & `CPC_CTRL_MASK;
                    `CPC_OFS_LIMIT:    limit     <= pwdata & `CPC_LIMIT_MASK;
                    `CPC_OFS_FLOOR:    floor_cfg <= pwdata[8:0];
                    `CPC_OFS_IRQ_MASK: irq_mask  <= pwdata[2:0];
                    default: ;
                endcase
            end
            // A new event wins over a clear in the same cycle
            irq_stat <= (irq_stat & ~w1c) | events;
            irq      <= |(((irq_stat & ~w1c) | events) & irq_mask);
        end
    end
endmodule

/* cpc_charge_phase_props.sv */
// Port checker for the charge phase sequencer
`timescale 1ns/1ps
module cpc_charge_phase_props #(
    parameter TICK_CYC = 20000
) (
    input wire        clk_sys,
    input wire        sys_rst,
    input wire        psel,
    input wire        penable,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        charge_mode,
    input wire        charge_enable,
    input wire [2:0]  phase_out,
    input wire        floor_active,
    input wire        eoc_flag,
    input wire        alert_n
);
    int low_cnt;
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst)
            low_cnt <= 0;
        else
            low_cnt <= alert_n ? 0 : low_cnt + 1;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    a_apb_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("access not answered after one wait");
    a_pready_single: assert property (pready |=> !pready) else $error("ready held");
    a_err_with_ready: assert property (pslverr |-> pready) else $error("stray error");
    a_prdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("data leak");
    a_alert_width: assert property ($rose(alert_n) |-> low_cnt == TICK_CYC)
        else $error("alert width wrong");
    a_eoc_entry: assert property ($rose(eoc_flag) |=> phase_out == 3'h4)
        else $error("flag outside end of charge");
    a_eoc_exit: assert property ($fell(eoc_flag) |=> phase_out inside {3'h0, 3'h2})
        else $error("flag cleared into wrong phase");
    a_enable_phase: assert property (charge_enable |-> phase_out != 3'h0)
        else $error("enabled while idle");
    a_discharge_idle: assert property (!charge_mode [*3] |-> phase_out == 3'h0)
        else $error("phase runs in discharge");
    a_floor_mode: assert property (floor_active |-> charge_mode)
        else $error("floor active in discharge");
    cover property ($rose(eoc_flag));
    cover property ($fell(alert_n));
    cover property (pready && pslverr);
endmodule

bind cpc_charge_phase cpc_charge_phase_props #(.TICK_CYC(TICK_CYC)) u_props (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .charge_mode(charge_mode),
    .charge_enable(charge_enable), .phase_out(phase_out), .floor_active(floor_active),
    .eoc_flag(eoc_flag), .alert_n(alert_n));

/* cpc_host_bfm.sv */
// Host model: APB master issuing one transfer at a time
`timescale 1ns/1ps
module cpc_host_bfm (
    input  wire         clk_sys,
    input  wire         pready,
    output logic        psel = 1'b0,
    output logic        penable = 1'b0,
    output logic        pwrite = 1'b0,
    output logic [7:0]  paddr = 8'h0,
    output logic [31:0] pwdata = 32'h0
);
    bit hung;
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        begin
            n = 0;
            @(posedge clk_sys);
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clk_sys);
            penable <= 1'b1;
            @(posedge clk_sys);
            while (pready !== 1'b1 && n < 40) begin
                n++;
                @(posedge clk_sys);
            end
            hung = (n >= 40);
            psel <= 1'b0;
            penable <= 1'b0;
            // Released lines must not keep looking valid
            paddr <= ~a;
            pwdata <= ~d;
        end
    endtask
endmodule

/* cpc_charge_phase_tb.sv */
// Self-checking bench for the charge phase sequencer
`timescale 1ns/1ps
module cpc_charge_phase_tb;
    logic clk_sys = 1'b0, sys_rst = 1'b1, power_stop_pin = 1'b1;
    logic [15:0] bat_mv = 16'h0, bus_mv = 16'h2328, bat_ma = 16'h1f4, bus_ma = 16'h1f4;
    logic [15:0] ext_target_mv = 16'h1f40;
    wire psel, penable, pwrite, pready, pslverr, charge_mode, charge_enable, bus_loop;
    wire floor_active, eoc_flag, irq, alert_n;
    wire [7:0] paddr;
    wire [31:0] pwdata, prdata;
    wire [2:0] phase_out;
    wire [15:0] bus_limit_ma, bat_limit_ma, vreg_mv;
    int n_fail, checks_done, wcnt, lowc;
    int seed = 32'h84e2;
    logic [31:0] rnd;
    logic [32:0] e;
    logic [32:0] exp_q[$];
    always #25 clk_sys = ~clk_sys;
    cpc_host_bfm u_cpc_host_bfm (.clk_sys(clk_sys), .pready(pready), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    cpc_charge_phase #(.TICK_CYC(20)) u_cpc_charge_phase (.clk_sys(clk_sys),
        .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .power_stop_pin(power_stop_pin), .bat_mv(bat_mv), .bus_mv(bus_mv), .bat_ma(bat_ma),
        .bus_ma(bus_ma), .ext_target_mv(ext_target_mv), .charge_mode(charge_mode),
        .charge_enable(charge_enable), .phase_out(phase_out), .bus_limit_ma(bus_limit_ma),
        .bat_limit_ma(bat_limit_ma), .vreg_mv(vreg_mv), .bus_loop(bus_loop),
        .floor_active(floor_active), .eoc_flag(eoc_flag), .irq(irq), .alert_n(alert_n));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        begin
            if (exp_q.size() != 0)
                n_fail++;
            $display("checks %0d mismatches %0d", checks_done, n_fail);
            if (n_fail == 0 && checks_done > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] want);
        begin
            checks_done++;
            if (got !== want) begin
                n_fail++;
                $display("FAIL t=%0t got %h exp %h", $time, got, want);
            end
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [32:0] want);
        begin
            exp_q.push_back(want);
            u_cpc_host_bfm.xfer(w, a, d);
            if (u_cpc_host_bfm.hung) begin
                n_fail++;
                report_and_stop();
            end
        end
    endtask
    task automatic wait_ph(input logic [2:0] p);
        begin
            wcnt = 0;
            while (phase_out !== p && wcnt < 6000) begin
                wcnt++;
                @(posedge clk_sys);
            end
            chk({13'h0, phase_out}, {13'h0, p});
            if (wcnt >= 6000)
                report_and_stop();
            repeat (2) @(posedge clk_sys);
        end
    endtask
    // Answers are compared in order of issue, at the edge that samples ready
    always @(posedge clk_sys) begin
        if (alert_n === 1'b0)
            lowc++;
        if (pready === 1'b1) begin
            e = exp_q.pop_front();
            checks_done++;
            if ({pslverr, prdata} !== e) begin
                n_fail++;
                $display("FAIL t=%0t got %h exp %h", $time, {pslverr, prdata}, e);
            end
        end
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        sys_rst <= 1'b0;
        apb(1'b0, 8'h00, 32'h0, 33'h1000);
        apb(1'b0, 8'h04, 32'h0, 33'hff7f);
        apb(1'b0, 8'h08, 32'h0, 33'h2c);
        apb(1'b0, 8'h1c, 32'h0, 33'h100000000);
        apb(1'b1, 8'h40, 32'h5, 33'h100000000);
        apb(1'b1, 8'h14, 32'h3, 33'h0);
        bat_mv <= 16'h0b72;
        power_stop_pin <= 1'b0;
        wait_ph(3'h1);
        chk({15'h0, wcnt > 32'h1112}, 16'h1);
        chk(bus_limit_ma, 16'h0528);
        chk({15'h0, charge_mode}, 16'h1);
        apb(1'b1, 8'h00, 32'h1002, 33'h0);
        wait_ph(3'h2);
        chk(bus_limit_ma, 16'h1770);
        chk(bat_limit_ma, 16'h1770);
        chk({15'h0, bus_loop}, 16'h1);
        bat_mv <= 16'h1018;
        wait_ph(3'h3);
        chk(vreg_mv, 16'h1068);
        rnd = $random(seed);
        bat_ma <= {6'h0, rnd[9:0]};
        apb(1'b1, 8'h04, 32'h0300ff7f, 33'h0);
        repeat (3) @(posedge clk_sys);
        chk(vreg_mv, 16'h1068 + {6'h0, rnd[9:0]} * 16'h3 / 16'h32);
        bat_ma <= 16'h1388;
        repeat (3) @(posedge clk_sys);
        chk(vreg_mv, 16'h10e5);
        chk({15'h0, bus_loop}, 16'h0);
        bat_ma <= 16'h0064;
        bus_ma <= 16'h00c8;
        lowc = 0;
        bat_mv <= 16'h1036;
        wait_ph(3'h4);
        chk({14'h0, eoc_flag, irq}, 16'h3);
        chk({15'h0, charge_enable}, 16'h0);
        repeat (50) @(posedge clk_sys);
        chk(lowc[15:0], 16'h14);
        apb(1'b0, 8'h10, 32'h0, 33'h1);
        apb(1'b1, 8'h10, 32'h1, 33'h0);
        repeat (2) @(posedge clk_sys);
        chk({15'h0, irq}, 16'h0);
        bat_mv <= 16'h0f3c;
        wait_ph(3'h2);
        chk({15'h0, eoc_flag}, 16'h0);
        apb(1'b1, 8'h00, 32'h1003, 33'h0);
        wait_ph(3'h0);
        chk({15'h0, charge_mode}, 16'h0);
        bat_mv <= 16'h07d0;
        apb(1'b1, 8'h00, 32'h7318, 33'h0);
        wait_ph(3'h2);
        chk(vreg_mv, 16'h1f40);
        apb(1'b0, 8'h18, 32'h0, 33'h11941f40);
        apb(1'b1, 8'h04, 32'h0002ff7f, 33'h0);
        repeat (3) @(posedge clk_sys);
        chk(bus_limit_ma, 16'h0bb8);
        apb(1'b1, 8'h04, 32'h0005ff7f, 33'h0);
        repeat (3) @(posedge clk_sys);
        chk(bus_limit_ma, 16'h1770);
        chk(bat_limit_ma, 16'h2ee0);
        bus_mv <= 16'h0fa0;
        repeat (40) @(posedge clk_sys);
        chk({14'h0, floor_active, bus_limit_ma < 16'h1770}, 16'h3);
        apb(1'b1, 8'h08, 32'h95, 33'h0);
        apb(1'b0, 8'h18, 32'h0, 33'h3a981f40);
        // Let the answer checker take the last reply first
        repeat (2) @(posedge clk_sys);
        report_and_stop();
    end
endmodule
